// [rtl/eye_ctrl_pkg.sv]
`default_nettype none
package eye_ctrl_pkg;
   // Register addresses on the host register port
   localparam logic [7:0] DEEMPH_ADDR = 8'h13;
   localparam logic [7:0] DEVCTL_ADDR = 8'h14;
   localparam logic [7:0] RXPD_ADDR   = 8'h15;
   // Reset values
   localparam logic [7:0] DEEMPH_RST  = 8'h00;
   localparam logic [7:0] DEVCTL_RST  = 8'h13;
   localparam logic [7:0] RXPD_RST    = 8'h00;
   localparam logic [7:0] UNMAPPED_RD = 8'h00;
   // Driver de-emphasis register fields
   localparam int EMPH0_HI     = 7;
   localparam int EMPH0_LO     = 6;
   localparam int EMPH1_HI     = 5;
   localparam int EMPH1_LO     = 4;
   localparam int EMPH_RSV_HI  = 3;
   localparam int EMPH_RSV_LO  = 0;
   // Device control register fields
   localparam int MUTE_LVL_BIT = 7;
   localparam int DEV_RSV_BIT  = 6;
   localparam int OVERRIDE_BIT = 5;
   localparam int MON_OFF_BIT  = 4;
   localparam int SPAN_HI      = 3;
   localparam int SPAN_LO      = 2;
   localparam int EQ_SEL_BIT   = 1;
   localparam int LOCK_CHK_BIT = 0;
   // Receiver power-down register fields
   localparam int IN3_OFF_BIT  = 7;
   localparam int IN2_OFF_BIT  = 6;
   // Secondary select codes and resulting input index
   localparam logic [1:0] SEL_IN0  = 2'h0;
   localparam logic [1:0] SEL_IN2A = 2'h1;
   localparam logic [1:0] SEL_IN2B = 2'h2;
   localparam logic [1:0] SEL_IN3  = 2'h3;
   localparam logic [1:0] IDX_IN0  = 2'h0;
   localparam logic [1:0] IDX_IN2  = 2'h2;
   localparam logic [1:0] IDX_IN3  = 2'h3;
   typedef enum logic [1:0] {EMPH_0DB, EMPH_3DB, EMPH_5DB, EMPH_7DB} emphasis_t;
   typedef enum logic [1:0] {SPAN_100MV, SPAN_200MV, SPAN_300MV, SPAN_400MV} span_t;
endpackage
`default_nettype wire

// [rtl/route_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface route_if;
   logic [1:0] primary_choice;
   logic [1:0] secondary_input_choice;
   logic       secondary_route_override;
   logic       equalized_in;
   logic [1:0] secondary_index;
   logic       equalized_out;
   modport ctrl (output primary_choice, output secondary_input_choice,
                 output secondary_route_override, output equalized_in,
                 input secondary_index, input equalized_out);
   modport mux  (input primary_choice, input secondary_input_choice,
                 input secondary_route_override, input equalized_in,
                 output secondary_index, output equalized_out);
endinterface
`default_nettype wire

// [rtl/ctrl_reg8.sv]
`timescale 1ns/1ps
`default_nettype none
module ctrl_reg8 #(
   parameter logic [7:0] ADDR  = 8'h00,
   parameter logic [7:0] RESET = 8'h00
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       wr_en,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wr_data,
   output var  logic [7:0] q
);
   // Every bit is plain storage; reserved bits keep what was written
   always_ff @(posedge clk) begin
      if (rst) begin
         q <= RESET;
      end else if (wr_en && (addr == ADDR)) begin
         q <= wr_data;
      end
   end
endmodule
`default_nettype wire

// [rtl/secondary_route_mux.sv]
`timescale 1ns/1ps
`default_nettype none
module secondary_route_mux
   import eye_ctrl_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   route_if.mux      rt
);
   logic [1:0] index_next;

   // Two select codes land on input 2; code 01 keeps the printed mapping
   always_comb begin
      if (!rt.secondary_route_override) begin
         index_next = rt.primary_choice;
      end else begin
         unique case (rt.secondary_input_choice)
            SEL_IN0:  index_next = IDX_IN0;
            SEL_IN2A: index_next = IDX_IN2;
            SEL_IN2B: index_next = IDX_IN2;
            SEL_IN3:  index_next = IDX_IN3;
         endcase
      end
   end

   // Registered so the analog mux sees a glitch-free select
   always_ff @(posedge clk) begin
      if (rst) begin
         rt.secondary_index <= IDX_IN0;
         rt.equalized_out   <= 1'b1;
      end else begin
         rt.secondary_index <= index_next;
         rt.equalized_out   <= rt.equalized_in;
      end
   end

   sel_map_a: assert property (@(posedge clk) disable iff (rst)
      rt.secondary_route_override && rt.secondary_input_choice == SEL_IN3
      |=> rt.secondary_index == IDX_IN3)
      else $error("secondary select 11 did not pick input 3");
endmodule
`default_nettype wire

// [rtl/reclocker_output_eye_monitor_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module reclocker_output_eye_monitor_ctrl (
   input  wire logic                   clk,
   input  wire logic                   rst,
   // Host register port
   input  wire logic                   wr_en,
   input  wire logic                   rd_en,
   input  wire logic [7:0]             addr,
   input  wire logic [7:0]             wr_data,
   output var  logic [7:0]             rd_data,
   // Selections and mute controls from neighbouring register slices
   input  wire logic [1:0]             primary_input_choice,
   input  wire logic [1:0]             secondary_input_choice,
   input  wire logic                   mute_ctrl,
   input  wire logic                   pin_control_override,
   // Controls toward the analog circuits
   output var  eye_ctrl_pkg::emphasis_t out0_emphasis_level,
   output var  eye_ctrl_pkg::emphasis_t out1_emphasis_level,
   output var  logic                   outputs_muted,
   output var  logic                   muted_level,
   output var  logic [1:0]             secondary_index,
   output var  logic                   secondary_equalized_choice,
   output var  logic                   eye_monitor_off,
   output var  eye_ctrl_pkg::span_t    eye_monitor_span,
   output var  logic                   double_lock_fail_check,
   output var  logic                   in3_detect_off,
   output var  logic                   in2_detect_off
);
   import eye_ctrl_pkg::*;

   logic [7:0] deemph_reg;
   logic [7:0] devctl_reg;
   logic [7:0] rxpd_reg;
   logic [7:0] rd_data_next;
   logic       muted_next;
   route_if    rt ();

   // The three control registers share one write port
   ctrl_reg8 #(
      .ADDR  (DEEMPH_ADDR),
      .RESET (DEEMPH_RST)
   ) u_deemph (
      .clk     (clk),
      .rst     (rst),
      .wr_en   (wr_en),
      .addr    (addr),
      .wr_data (wr_data),
      .q       (deemph_reg)
   );

   ctrl_reg8 #(
      .ADDR  (DEVCTL_ADDR),
      .RESET (DEVCTL_RST)
   ) u_devctl (
      .clk     (clk),
      .rst     (rst),
      .wr_en   (wr_en),
      .addr    (addr),
      .wr_data (wr_data),
      .q       (devctl_reg)
   );

   ctrl_reg8 #(
      .ADDR  (RXPD_ADDR),
      .RESET (RXPD_RST)
   ) u_rxpd (
      .clk     (clk),
      .rst     (rst),
      .wr_en   (wr_en),
      .addr    (addr),
      .wr_data (wr_data),
      .q       (rxpd_reg)
   );

   // Field decode; the registers themselves are the flip-flops
   always_comb begin
      out0_emphasis_level = emphasis_t'(deemph_reg[EMPH0_HI:EMPH0_LO]);
      out1_emphasis_level = emphasis_t'(deemph_reg[EMPH1_HI:EMPH1_LO]);
      eye_monitor_off        = devctl_reg[MON_OFF_BIT];
      eye_monitor_span       = span_t'(devctl_reg[SPAN_HI:SPAN_LO]);
      double_lock_fail_check = devctl_reg[LOCK_CHK_BIT];
      in3_detect_off         = rxpd_reg[IN3_OFF_BIT];
      in2_detect_off         = rxpd_reg[IN2_OFF_BIT];
   end

   // Secondary routing is resolved and registered in its own module
   always_comb begin
      rt.primary_choice           = primary_input_choice;
      rt.secondary_input_choice   = secondary_input_choice;
      rt.secondary_route_override = devctl_reg[OVERRIDE_BIT];
      rt.equalized_in             = devctl_reg[EQ_SEL_BIT];
      secondary_index             = rt.secondary_index;
      secondary_equalized_choice  = rt.equalized_out;
   end

   secondary_route_mux u_route (
      .clk (clk),
      .rst (rst),
      .rt  (rt.mux)
   );

   // Mute only acts while the pin override is clear
   assign muted_next = !mute_ctrl && !pin_control_override;

   // Registered mute so both drivers switch in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         outputs_muted <= 1'b0;
         muted_level   <= 1'b0;
      end else begin
         outputs_muted <= muted_next;
         muted_level   <= devctl_reg[MUTE_LVL_BIT];
      end
   end

   // Readback mux; reserved bits return what was stored
   always_comb begin
      unique case (addr)
         DEEMPH_ADDR: rd_data_next = deemph_reg;
         DEVCTL_ADDR: rd_data_next = devctl_reg;
         RXPD_ADDR:   rd_data_next = rxpd_reg;
         default:     rd_data_next = UNMAPPED_RD;
      endcase
   end

   // Read data is held until the next read so the host can sample late
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data <= UNMAPPED_RD;
      end else if (rd_en) begin
         rd_data <= rd_data_next;
      end
   end

   // Host write cycles to each register, and the reset release
   sequence deemph_wr;
      wr_en && addr == DEEMPH_ADDR;
   endsequence

   sequence devctl_wr;
      wr_en && addr == DEVCTL_ADDR;
   endsequence

   sequence rxpd_wr;
      wr_en && addr == RXPD_ADDR;
   endsequence

   sequence reset_release;
      rst ##1 !rst;
   endsequence

   // Host read cycles that the readback checks key on
   sequence deemph_rd;
      rd_en && addr == DEEMPH_ADDR;
   endsequence

   sequence rxpd_rd;
      rd_en && addr == RXPD_ADDR;
   endsequence

   emph0_field_a: assert property (@(posedge clk) disable iff (rst)
      deemph_wr |=> out0_emphasis_level == emphasis_t'($past(wr_data[EMPH0_HI:EMPH0_LO])))
      else $error("driver 0 emphasis did not take written value");

   emph1_field_a: assert property (@(posedge clk) disable iff (rst)
      deemph_wr |=> out1_emphasis_level == emphasis_t'($past(wr_data[EMPH1_HI:EMPH1_LO])))
      else $error("driver 1 emphasis did not take written value");

   emph_reserved_a: assert property (@(posedge clk) disable iff (rst)
      deemph_wr ##1 !wr_en ##1 (rd_en && addr == DEEMPH_ADDR && !wr_en)
      |=> rd_data[EMPH_RSV_HI:EMPH_RSV_LO] == $past(wr_data[EMPH_RSV_HI:EMPH_RSV_LO], 3))
      else $error("reserved emphasis bits lost their stored value");

   mute_level_a: assert property (@(posedge clk) disable iff (rst)
      devctl_wr ##1 !wr_en |=> muted_level == $past(wr_data[MUTE_LVL_BIT], 2))
      else $error("muted level does not follow device control bit 7");

   mute_gate_a: assert property (@(posedge clk) disable iff (rst)
      (!mute_ctrl && !pin_control_override) |=> outputs_muted)
      else $error("outputs not muted with mute control low");

   mute_override_a: assert property (@(posedge clk) disable iff (rst)
      (mute_ctrl || pin_control_override) |=> !outputs_muted)
      else $error("outputs muted while mute control inactive");

   route_follow_a: assert property (@(posedge clk) disable iff (rst)
      !devctl_reg[OVERRIDE_BIT] |=> secondary_index == $past(primary_input_choice))
      else $error("secondary path did not follow primary selection");

   route_override_a: assert property (@(posedge clk) disable iff (rst)
      devctl_reg[OVERRIDE_BIT] && secondary_input_choice == SEL_IN2A
      |=> secondary_index == IDX_IN2)
      else $error("override did not use secondary select field");

   reset_values_a: assert property (@(posedge clk)
      reset_release |-> eye_monitor_off && double_lock_fail_check
      && secondary_equalized_choice && !devctl_reg[DEV_RSV_BIT]
      && out0_emphasis_level == EMPH_0DB && !in3_detect_off)
      else $error("control fields wrong after reset");

   span_write_a: assert property (@(posedge clk) disable iff (rst)
      devctl_wr |=> eye_monitor_span == span_t'($past(wr_data[SPAN_HI:SPAN_LO])))
      else $error("eye monitor span did not take written value");

   eq_choice_a: assert property (@(posedge clk) disable iff (rst)
      devctl_wr ##1 !wr_en |=> secondary_equalized_choice == $past(wr_data[EQ_SEL_BIT], 2))
      else $error("equalized choice did not reach the secondary path");

   lock_check_a: assert property (@(posedge clk) disable iff (rst)
      devctl_wr |=> double_lock_fail_check == $past(wr_data[LOCK_CHK_BIT]))
      else $error("lock check strictness did not take written value");

   detect_off_a: assert property (@(posedge clk) disable iff (rst)
      rxpd_wr |=> in3_detect_off == $past(wr_data[IN3_OFF_BIT])
      && in2_detect_off == $past(wr_data[IN2_OFF_BIT]))
      else $error("signal detect power-down bits wrong after write");

   rsvd_bit6_a: assert property (@(posedge clk) disable iff (rst)
      (rd_en && addr == DEVCTL_ADDR) |=> rd_data[DEV_RSV_BIT] == $past(devctl_reg[DEV_RSV_BIT]))
      else $error("reserved device control bit readback wrong");

   unmapped_rd_a: assert property (@(posedge clk) disable iff (rst)
      (rd_en && addr != DEEMPH_ADDR && addr != DEVCTL_ADDR && addr != RXPD_ADDR)
      |=> rd_data == UNMAPPED_RD)
      else $error("unmapped read returned nonzero data");

   // Registers move only on a write to their own address
   emph_hold_a: assert property (@(posedge clk) disable iff (rst)
      !(wr_en && addr == DEEMPH_ADDR) |=> $stable(deemph_reg))
      else $error("de-emphasis register changed without a write");

   devctl_hold_a: assert property (@(posedge clk) disable iff (rst)
      !(wr_en && addr == DEVCTL_ADDR) |=> $stable(devctl_reg))
      else $error("device control register changed without a write");

   rxpd_hold_a: assert property (@(posedge clk) disable iff (rst)
      !(wr_en && addr == RXPD_ADDR) |=> $stable(rxpd_reg))
      else $error("power-down register changed without a write");

   // Every register and registered output except the equalized choice at its reset value on release
   emph_reset_a: assert property (@(posedge clk)
      reset_release |-> deemph_reg == DEEMPH_RST && rd_data == UNMAPPED_RD)
      else $error("de-emphasis register or read data wrong after reset");

   devctl_reset_a: assert property (@(posedge clk)
      reset_release |-> devctl_reg == DEVCTL_RST && !muted_level && !outputs_muted)
      else $error("device control register wrong after reset");

   rxpd_reset_a: assert property (@(posedge clk)
      reset_release |-> rxpd_reg == RXPD_RST && !in2_detect_off && secondary_index == IDX_IN0)
      else $error("power-down register or secondary index wrong after reset");

   // Eye monitor power-down and reserved bits take the written value one cycle later
   mon_off_a: assert property (@(posedge clk) disable iff (rst)
      devctl_wr |=> eye_monitor_off == $past(wr_data[MON_OFF_BIT]))
      else $error("eye monitor power-down did not take written value");

   rsvd_store_a: assert property (@(posedge clk) disable iff (rst)
      devctl_wr |=> devctl_reg[DEV_RSV_BIT] == $past(wr_data[DEV_RSV_BIT]))
      else $error("reserved device control bit not stored");

   emph_rsv_store_a: assert property (@(posedge clk) disable iff (rst)
      deemph_wr |=> deemph_reg[EMPH_RSV_HI:EMPH_RSV_LO]
      == $past(wr_data[EMPH_RSV_HI:EMPH_RSV_LO]))
      else $error("reserved de-emphasis bits not stored");

   // Remaining secondary select codes under override
   route_code0_a: assert property (@(posedge clk) disable iff (rst)
      devctl_reg[OVERRIDE_BIT] && secondary_input_choice == SEL_IN0
      |=> secondary_index == IDX_IN0)
      else $error("secondary select 00 did not pick input 0");

   route_code2_a: assert property (@(posedge clk) disable iff (rst)
      devctl_reg[OVERRIDE_BIT] && secondary_input_choice == SEL_IN2B
      |=> secondary_index == IDX_IN2)
      else $error("secondary select 10 did not pick input 2");

   // Read data stands until the next read strobe
   rd_hold_a: assert property (@(posedge clk) disable iff (rst)
      !rd_en |=> $stable(rd_data))
      else $error("read data changed without a read");

   // Readback fields agree with the controls they drive
   emph_read_a: assert property (@(posedge clk) disable iff (rst)
      deemph_rd |=> rd_data[EMPH0_HI:EMPH0_LO] == $past(out0_emphasis_level)
      && rd_data[EMPH1_HI:EMPH1_LO] == $past(out1_emphasis_level))
      else $error("de-emphasis readback disagrees with driver levels");

   rxpd_read_a: assert property (@(posedge clk) disable iff (rst)
      rxpd_rd |=> rd_data[IN3_OFF_BIT] == $past(in3_detect_off)
      && rd_data[IN2_OFF_BIT] == $past(in2_detect_off))
      else $error("power-down readback disagrees with detect controls");

   span_read_a: assert property (@(posedge clk) disable iff (rst)
      (rd_en && addr == DEVCTL_ADDR) |=> rd_data[SPAN_HI:SPAN_LO] == $past(eye_monitor_span)
      && rd_data[MON_OFF_BIT] == $past(eye_monitor_off))
      else $error("device control readback disagrees with monitor controls");
endmodule
`default_nettype wire

// [bench/cfg_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
   input  wire logic       clk,
   output var  logic       wr_en,
   output var  logic       rd_en,
   output var  logic [7:0] addr,
   output var  logic [7:0] wr_data
);
   import eye_ctrl_pkg::*;
   // Idle from time zero so nothing strobes during reset
   initial begin
      wr_en   = 1'b0;
      rd_en   = 1'b0;
      addr    = 8'h00;
      wr_data = 8'h00;
   end
   // One-cycle write; reserved bits only ever get their reset value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a == DEEMPH_ADDR) v[EMPH_RSV_HI:EMPH_RSV_LO] = 4'h0;
      if (a == DEVCTL_ADDR) v[DEV_RSV_BIT] = 1'b0;
      @(posedge clk);
      wr_en   <= 1'b1;
      addr    <= a;
      wr_data <= v;
      @(posedge clk);
      wr_en   <= 1'b0;
      wr_data <= ~v; // Stale data is not left on the port
   endtask
   // One-cycle read; data is taken by the bench one cycle later
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      rd_en <= 1'b1;
      addr  <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      addr  <= ~a;
   endtask
endmodule
`default_nettype wire

// [bench/reclocker_output_eye_monitor_ctrl_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module reclocker_output_eye_monitor_ctrl_tb;
   import eye_ctrl_pkg::*;
   logic       clk, rst, wr_en, rd_en, mute_ctrl, pin_ovr;
   logic [7:0] addr, wr_data, rd_data, d;
   logic [1:0] prim, sec, sidx;
   emphasis_t  e0, e1;
   span_t      span;
   logic       muted, mlvl, eq, moff, lchk, in3, in2;
   logic [7:0] rd_q[$];
   int         mismatches, cmp_count;
   cfg_host_model host_u (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
                          .wr_data(wr_data));
   reclocker_output_eye_monitor_ctrl dut_u (.clk(clk), .rst(rst), .wr_en(wr_en),
      .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
      .primary_input_choice(prim), .secondary_input_choice(sec), .mute_ctrl(mute_ctrl),
      .pin_control_override(pin_ovr), .out0_emphasis_level(e0), .out1_emphasis_level(e1),
      .outputs_muted(muted), .muted_level(mlvl), .secondary_index(sidx),
      .secondary_equalized_choice(eq), .eye_monitor_off(moff), .eye_monitor_span(span),
      .double_lock_fail_check(lchk), .in3_detect_off(in3), .in2_detect_off(in2));
   // Clock, 25 ns period
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wrap_up();
      if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Read data shows one cycle after the strobe edge, oldest note first
   always @(posedge clk) begin
      if (rd_en === 1'b1) begin
         #1;
         if (rd_q.size() == 0) chk8("rd_queue", 8'h00, 8'hFF);
         else chk8("rd_data", rd_q.pop_front(), rd_data);
      end
   end
   task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
      rd_q.push_back(e);
      host_u.rd(a);
   endtask
   // Let writes reach every output, including the two-stage ones
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask
   function automatic logic [1:0] exp_idx(input logic ov);
      if (!ov) return prim;
      return (sec == SEL_IN0) ? IDX_IN0 : (sec == SEL_IN3) ? IDX_IN3 : IDX_IN2;
   endfunction
   task automatic chk_route(input logic ov);
      chk8("outputs_muted", {7'h00, ~mute_ctrl & ~pin_ovr}, {7'h00, muted});
      chk8("secondary_index", {6'h00, exp_idx(ov)}, {6'h00, sidx});
   endtask
   // Reset held 12 cycles, then every reset value is checked
   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      settle();
      chk8("emph", 8'h00, {2'h0, e0, 2'h0, e1});
      chk8("dev_fields", 8'h13, {mlvl, 2'h0, moff, span, eq, lchk});
      chk8("detect", 8'h00, {6'h00, in3, in2});
      chk_route(1'b0);
      rd_exp(DEEMPH_ADDR, DEEMPH_RST);
      rd_exp(DEVCTL_ADDR, DEVCTL_RST);
      rd_exp(RXPD_ADDR, RXPD_RST);
   endtask
   initial begin
      rst = 1'b1;
      mute_ctrl = 1'b1;
      pin_ovr = 1'b0;
      prim = 2'h0;
      sec = 2'h0;
      mismatches = 0;
      cmp_count = 0;
      void'($urandom(32'hb41a3096));
      do_reset();
      // Every de-emphasis code on both drivers
      for (int i = 0; i < 16; i++) begin
         d = {i[3:0], 4'($urandom)};
         host_u.wr(DEEMPH_ADDR, d);
         rd_exp(DEEMPH_ADDR, {d[7:4], 4'h0});
         settle();
         chk8("out0_emph", {6'h00, d[7:6]}, {6'h00, e0});
         chk8("out1_emph", {6'h00, d[5:4]}, {6'h00, e1});
      end
      // Device control fields, every span and secondary code, mute combos
      for (int i = 0; i < 32; i++) begin
         d = 8'($urandom);
         d[DEV_RSV_BIT] = 1'b0;
         d[SPAN_HI:SPAN_LO] = i[1:0];
         d[OVERRIDE_BIT] = i[2];
         host_u.wr(DEVCTL_ADDR, d);
         @(posedge clk);
         sec <= i[1:0];
         prim <= 2'($urandom);
         mute_ctrl <= i[3];
         pin_ovr <= i[4];
         settle();
         chk8("muted_level", {7'h00, d[7]}, {7'h00, mlvl});
         chk8("eye_off", {7'h00, d[4]}, {7'h00, moff});
         chk8("span", {6'h00, d[3:2]}, {6'h00, span});
         chk8("eq_choice", {7'h00, d[1]}, {7'h00, eq});
         chk8("lock_chk", {7'h00, d[0]}, {7'h00, lchk});
         chk_route(d[OVERRIDE_BIT]);
         rd_exp(DEVCTL_ADDR, d);
      end
      // Detect power-downs, then an unmapped write that must change nothing
      for (int i = 0; i < 4; i++) begin
         d = {i[1:0], 6'($urandom)};
         host_u.wr(RXPD_ADDR, d);
         settle();
         chk8("detect_off", {6'h00, d[7:6]}, {6'h00, in3, in2});
      end
      host_u.wr(8'h16, 8'hFF);
      rd_exp(8'h16, UNMAPPED_RD);
      rd_exp(RXPD_ADDR, d);
      // Second reset in mid-run restores every register
      do_reset();
      settle();
      wrap_up();
   end
   // Watchdog well beyond the expected run length
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      wrap_up();
   end
endmodule
`default_nettype wire
